/* tpw_pkg.sv */
/*
  tpw_pkg: shared constants and types for the 16-bit PWM timer block.
  Assumes a single 20 MHz clock; register offsets are APB byte addresses.
*/
package tpw_pkg;

  // apb byte offsets, one aligned word per register
  localparam logic [7:0] OFS_CTRL1   = 8'h00;
  localparam logic [7:0] OFS_CTRL2   = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_CMP1_HI = 8'h0C;
  localparam logic [7:0] OFS_CMP1_LO = 8'h10;
  localparam logic [7:0] OFS_CMP2_HI = 8'h14;
  localparam logic [7:0] OFS_CMP2_LO = 8'h18;
  localparam logic [7:0] OFS_CAP1_HI = 8'h1C;
  localparam logic [7:0] OFS_CAP1_LO = 8'h20;
  localparam logic [7:0] OFS_CAP2_HI = 8'h24;
  localparam logic [7:0] OFS_CAP2_LO = 8'h28;
  localparam logic [7:0] OFS_CNT_HI  = 8'h2C;
  localparam logic [7:0] OFS_CNT_LO  = 8'h30;

  // control 1 field positions
  localparam int B_CAP_IE   = 7;
  localparam int B_MATCH_IE = 6;
  localparam int B_OVF_IE   = 5;
  localparam int B_LEVEL2   = 2;
  localparam int B_CAP1_RISE = 1;
  localparam int B_LEVEL1   = 0;
  localparam logic [7:0] CTRL1_MASK = 8'hE7;
  // control 2 field positions
  localparam int B_PIN_EN   = 7;
  localparam int B_ONE_PULSE = 5;
  localparam int B_PWM      = 4;
  localparam int B_CLK_HI   = 3;
  localparam int B_CLK_LO   = 2;
  localparam int B_CAP2_RISE = 1;
  localparam int B_EXT_RISE = 0;
  localparam logic [7:0] CTRL2_MASK = 8'hBF;
  // flag vector positions, status reads {flags, 3'b000}
  localparam int F_CAP1   = 4;
  localparam int F_MATCH1 = 3;
  localparam int F_OVF    = 2;
  localparam int F_CAP2   = 1;
  localparam int F_MATCH2 = 0;

  // reset and reload values
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET  = 16'h8000;
  localparam logic [15:0] CNT_RESET  = 16'hFFFC;
  localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;

  typedef enum logic [1:0] {
    CK_DIV4 = 2'b00,
    CK_DIV2 = 2'b01,
    CK_DIV8 = 2'b10,
    CK_EXT  = 2'b11
  } tpw_clk_sel_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tpw_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tpw_apb_rsp_t;

  // pins from outside the clock domain: ext clock, capture 1, capture 2
  typedef struct packed {
    logic ext_clk;
    logic cap1;
    logic cap2;
  } tpw_pins_t;

  // processor state, same clock domain
  typedef struct packed {
    logic halt_mode;
    logic wait_mode;
    logic halt_irq_exit;
    logic global_mask;
  } tpw_cpu_t;

  typedef struct packed {
    logic [7:0]       ctrl1;
    logic [7:0]       ctrl2;
    logic [15:0]      cnt;
    logic [1:0][15:0] cmp_buf;
    logic [1:0][15:0] cmp_act;
    logic [1:0]       inhibit;
    logic [4:0]       flags;
    logic [4:0]       seen;
    logic [1:0][15:0] cap;
    logic [1:0]       cap_pend;
    logic [2:0]       presc;
    logic             wave;
    logic [31:0]      prdata;
    logic [2:0]       sync1;
    logic [2:0]       sync2;
    logic [2:0]       prev;
  } tpw_state_t;

endpackage

/* tpw_timer.sv */
/*
  tpw_timer: 16-bit free-running timer in pwm mode with capture, flags,
  shared interrupt and halt/wait behaviour, reached over apb.
  Assumes pins are asynchronous and cpu state ports are on clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tpw_timer (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire tpw_pkg::tpw_apb_req_t apb_req,
  output var  tpw_pkg::tpw_apb_rsp_t apb_rsp,
  input  wire tpw_pkg::tpw_pins_t    pins,
  input  wire tpw_pkg::tpw_cpu_t     cpu,
  output logic                   waveform_out_pin,
  output logic                   waveform_oe_n,
  output logic                   timer_irq,
  output logic                   wait_wake
);
  import tpw_pkg::*;

  tpw_state_t st;
  tpw_state_t next_st;

  // edge of a synchronised level, polarity chosen by rise
  function automatic logic edge_of(input logic cur, input logic prv,
                                   input logic rise);
    edge_of = rise ? (cur & ~prv) : (~cur & prv);
  endfunction

  // decode shared by read/write access qualifiers and error answer
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= OFS_CNT_LO) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [7:0] read_byte(input tpw_state_t s,
                                           input logic [7:0] a);
    unique case (a)
      OFS_CTRL1:   read_byte = s.ctrl1;
      OFS_CTRL2:   read_byte = s.ctrl2;
      OFS_STATUS:  read_byte = {s.flags, 3'b000};
      OFS_CMP1_HI: read_byte = s.cmp_buf[0][15:8];
      OFS_CMP1_LO: read_byte = s.cmp_buf[0][7:0];
      OFS_CMP2_HI: read_byte = s.cmp_buf[1][15:8];
      OFS_CMP2_LO: read_byte = s.cmp_buf[1][7:0];
      OFS_CAP1_HI: read_byte = s.cap[0][15:8];
      OFS_CAP1_LO: read_byte = s.cap[0][7:0];
      OFS_CAP2_HI: read_byte = s.cap[1][15:8];
      OFS_CAP2_LO: read_byte = s.cap[1][7:0];
      OFS_CNT_HI:  read_byte = s.cnt[15:8];
      OFS_CNT_LO:  read_byte = s.cnt[7:0];
      default:     read_byte = 8'h00;
    endcase
  endfunction

  logic         halted;
  logic         pwm_act;
  tpw_clk_sel_t clk_sel;
  logic         ext_edge;
  logic         cap1_edge;
  logic         cap2_edge;
  logic         tick;
  logic         m1_hit;
  logic         m2_hit;
  logic         per_match;
  logic [4:0]   set_vec;
  logic         access;
  logic         acc_wr;
  logic         acc_rd;

  assign halted  = cpu.halt_mode;
  assign pwm_act = st.ctrl2[B_PWM];
  assign clk_sel = tpw_clk_sel_t'(st.ctrl2[B_CLK_HI:B_CLK_LO]);

  // edges read only second stage and its delayed copy
  assign ext_edge  = edge_of(st.sync2[2], st.prev[2], st.ctrl2[B_EXT_RISE]);
  assign cap1_edge = edge_of(st.sync2[1], st.prev[1], st.ctrl1[B_CAP1_RISE]);
  assign cap2_edge = edge_of(st.sync2[0], st.prev[0], st.ctrl2[B_CAP2_RISE]);

  // timer clock enable; halt stops every tick
  always_comb begin
    unique case (clk_sel)
      CK_DIV4: tick = (st.presc[1:0] == 2'b11);
      CK_DIV2: tick = st.presc[0];
      CK_DIV8: tick = (st.presc == 3'b111);
      CK_EXT:  tick = ext_edge;
    endcase
    if (halted) begin
      tick = 1'b0;
    end
  end

  // matches on every tick, suppressed while a high byte is pending
  assign m1_hit = tick && !st.inhibit[0]
                  && (st.cnt == st.cmp_act[0]);
  assign m2_hit = tick && !st.inhibit[1]
                  && (st.cnt == st.cmp_act[1]);
  assign per_match = pwm_act && m2_hit;

  // hardware flag sets; pwm steals compare flags and capture pin 1
  always_comb begin
    set_vec = 5'b00000;
    set_vec[F_MATCH1] = !pwm_act && m1_hit;
    set_vec[F_MATCH2] = !pwm_act && m2_hit;
    set_vec[F_OVF] = tick && !per_match && (st.cnt == CNT_MAX);
    set_vec[F_CAP1] = per_match
                    || (!pwm_act && !halted && cap1_edge)
                    || (cpu.halt_irq_exit && st.cap_pend[0]);
    set_vec[F_CAP2] = (!halted && cap2_edge)
                    || (cpu.halt_irq_exit && st.cap_pend[1]);
  end

  assign access = apb_req.psel && apb_req.penable;
  assign acc_wr = access && apb_req.pwrite && addr_ok(apb_req.paddr);
  assign acc_rd = access && !apb_req.pwrite && addr_ok(apb_req.paddr);

  // next state of the whole block
  always_comb begin
    logic [4:0] clr;
    logic [4:0] lo_acc;
    clr = 5'b00000;
    lo_acc = 5'b00000;
    next_st = st;
    // two-stage synchroniser, then a delayed copy for edges
    next_st.sync1 = {pins.ext_clk, pins.cap1, pins.cap2};
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;
    if (!halted) begin
      next_st.presc = st.presc + 3'd1;
    end
    // counter: reload at period end, else add one
    if (per_match) begin
      next_st.cnt = CNT_RELOAD;
    end else if (tick) begin
      next_st.cnt = st.cnt + 16'h0001;
    end
    // waveform level; period end has priority over pulse edge
    if (per_match) begin
      next_st.wave = st.ctrl1[B_LEVEL2];
    end else if (m1_hit) begin
      next_st.wave = st.ctrl1[B_LEVEL1];
    end
    // active compare values: shadowed in pwm, direct otherwise
    if (!pwm_act) begin
      next_st.cmp_act = st.cmp_buf;
    end else if (per_match) begin
      next_st.cmp_act = st.cmp_buf;
    end
    // captures; edges during halt only arm the detector
    if (halted) begin
      if (cap1_edge && !pwm_act) begin
        next_st.cap_pend[0] = 1'b1;
      end
      if (cap2_edge) begin
        next_st.cap_pend[1] = 1'b1;
      end
    end else begin
      if (cap1_edge && !pwm_act) begin
        next_st.cap[0] = st.cnt;
      end
      if (cap2_edge) begin
        next_st.cap[1] = st.cnt;
      end
    end
    if (cpu.halt_irq_exit) begin
      if (st.cap_pend[0]) begin
        next_st.cap[0] = st.cnt;
      end
      if (st.cap_pend[1]) begin
        next_st.cap[1] = st.cnt;
      end
      next_st.cap_pend = 2'b00;
    end
    // apb setup cycle latches read data for the access phase
    if (apb_req.psel && !apb_req.penable) begin
      next_st.prdata = {24'h00_0000, read_byte(st, apb_req.paddr)};
    end
    // status read arms the clear of flags that are set now
    if (acc_rd && apb_req.paddr == OFS_STATUS) begin
      next_st.seen = st.flags;
    end
    if (access && addr_ok(apb_req.paddr)) begin
      lo_acc[F_CAP1]   = (apb_req.paddr == OFS_CAP1_LO);
      lo_acc[F_MATCH1] = (apb_req.paddr == OFS_CMP1_LO);
      lo_acc[F_OVF]    = (apb_req.paddr == OFS_CNT_LO);
      lo_acc[F_CAP2]   = (apb_req.paddr == OFS_CAP2_LO);
      lo_acc[F_MATCH2] = (apb_req.paddr == OFS_CMP2_LO);
    end
    clr = lo_acc & st.seen;
    next_st.seen = next_st.seen & ~lo_acc;
    // register writes; read-only words ignore writes
    if (acc_wr) begin
      unique case (apb_req.paddr)
        OFS_CTRL1: next_st.ctrl1 = apb_req.pwdata[7:0] & CTRL1_MASK;
        OFS_CTRL2: next_st.ctrl2 = apb_req.pwdata[7:0] & CTRL2_MASK;
        OFS_CMP1_HI: begin
          next_st.cmp_buf[0][15:8] = apb_req.pwdata[7:0];
          next_st.inhibit[0] = 1'b1;
        end
        OFS_CMP1_LO: begin
          next_st.cmp_buf[0][7:0] = apb_req.pwdata[7:0];
          next_st.inhibit[0] = 1'b0;
        end
        OFS_CMP2_HI: begin
          next_st.cmp_buf[1][15:8] = apb_req.pwdata[7:0];
          next_st.inhibit[1] = 1'b1;
        end
        OFS_CMP2_LO: begin
          next_st.cmp_buf[1][7:0] = apb_req.pwdata[7:0];
          next_st.inhibit[1] = 1'b0;
        end
        default: ;
      endcase
    end
    // set wins over a clear in the same cycle
    next_st.flags = (st.flags & ~clr) | set_vec;
  end

  // single state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      next_st_reset: begin
        st.ctrl1    <= CTRL_RESET;
        st.ctrl2    <= CTRL_RESET;
        st.cnt      <= CNT_RESET;
        st.cmp_buf  <= {CMP_RESET, CMP_RESET};
        st.cmp_act  <= {CMP_RESET, CMP_RESET};
        st.inhibit  <= 2'b00;
        st.flags    <= 5'b00000;
        st.seen     <= 5'b00000;
        st.cap      <= {16'h0000, 16'h0000};
        st.cap_pend <= 2'b00;
        st.presc    <= 3'b000;
        st.wave     <= 1'b0;
        st.prdata   <= 32'h0000_0000;
        st.sync1    <= 3'b000;
        st.sync2    <= 3'b000;
        st.prev     <= 3'b000;
      end
    end else begin
      st <= next_st;
    end
  end

  // zero-wait slave; unmapped words answer with an error
  assign apb_rsp = '{
    prdata:  st.prdata,
    pready:  1'b1,
    pslverr: access && !addr_ok(apb_req.paddr)
  };

  // pin is driven only when software hands it to the timer
  assign waveform_out_pin = st.wave;
  assign waveform_oe_n    = ~st.ctrl2[B_PIN_EN];

  // one shared request line; wait wake but never halt wake
  logic irq_src;
  assign irq_src = (st.ctrl1[B_CAP_IE]
                    && (st.flags[F_CAP1] || st.flags[F_CAP2]))
                || (st.ctrl1[B_MATCH_IE]
                    && (st.flags[F_MATCH1] || st.flags[F_MATCH2]))
                || (st.ctrl1[B_OVF_IE] && st.flags[F_OVF]);
  assign timer_irq = irq_src && !cpu.global_mask;
  assign wait_wake = timer_irq && cpu.wait_mode && !halted;

  property p_reload;
    @(posedge clock) disable iff (rst)
      per_match |=> (st.cnt == 16'hFFFC);
  endproperty
  a_reload: assert property (p_reload)
    else $error("counter not reloaded at period end");

  property p_no_match_flag;
    @(posedge clock) disable iff (rst)
      pwm_act |=> !$rose(st.flags[F_MATCH1]) && !$rose(st.flags[F_MATCH2]);
  endproperty
  a_no_match_flag: assert property (p_no_match_flag)
    else $error("compare flag set in pwm mode");

  property p_period_flag;
    @(posedge clock) disable iff (rst)
      per_match |=> st.flags[F_CAP1];
  endproperty
  a_period_flag: assert property (p_period_flag)
    else $error("capture flag 1 missing at period end");

  property p_levels;
    @(posedge clock) disable iff (rst)
      per_match |=> (waveform_out_pin == $past(st.ctrl1[B_LEVEL2]));
  endproperty
  a_levels: assert property (p_levels)
    else $error("pin did not take second level");

  property p_pulse_edge;
    @(posedge clock) disable iff (rst)
      m1_hit && !per_match |=> (waveform_out_pin == $past(st.ctrl1[B_LEVEL1]));
  endproperty
  a_pulse_edge: assert property (p_pulse_edge)
    else $error("pin did not take first level");

  property p_inhibit;
    @(posedge clock) disable iff (rst)
      acc_wr && (apb_req.paddr == OFS_CMP1_HI) |=> st.inhibit[0] && !m1_hit;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("compare active while high byte pending");

  property p_inhibit_end;
    @(posedge clock) disable iff (rst)
      acc_wr && (apb_req.paddr == OFS_CMP1_LO) |=> !st.inhibit[0];
  endproperty
  a_inhibit_end: assert property (p_inhibit_end)
    else $error("compare still inhibited after low byte");

  property p_cap1_cut;
    @(posedge clock) disable iff (rst)
      pwm_act && !cpu.halt_irq_exit |=> $stable(st.cap[0]);
  endproperty
  a_cap1_cut: assert property (p_cap1_cut)
    else $error("capture 1 loaded in pwm mode");

  property p_arm_halt;
    @(posedge clock) disable iff (rst)
      halted && cap2_edge && !cpu.halt_irq_exit |=> st.cap_pend[1];
  endproperty
  a_arm_halt: assert property (p_arm_halt)
    else $error("capture edge in halt not armed");

  property p_halt_freeze;
    @(posedge clock) disable iff (rst)
      halted ##1 halted |-> $stable(st.cnt);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze)
    else $error("counter moved during halt");

  property p_irq_mask;
    @(posedge clock) disable iff (rst)
      cpu.global_mask |-> !timer_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt while globally masked");

  property p_no_halt_wake;
    @(posedge clock) disable iff (rst)
      halted |-> !wait_wake;
  endproperty
  a_no_halt_wake: assert property (p_no_halt_wake)
    else $error("timer event woke from halt");

  property p_shadow;
    @(posedge clock) disable iff (rst)
      pwm_act && !per_match |=> $stable(st.cmp_act);
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("compare value changed mid period");

  property p_overflow;
    @(posedge clock) disable iff (rst)
      tick && !per_match && (st.cnt == 16'hFFFF)
        |=> st.flags[F_OVF] && (st.cnt == 16'h0000);
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow not flagged on rollover");

endmodule
`default_nettype wire

/* tpw_timer_tb.sv */
/*
  tpw_timer_tb: self-checking bench for the pwm timer over apb.
  Assumes tpw_pkg offsets and the load model tpw_wave_load.
*/
`timescale 1ns/100ps
`default_nettype none
module tpw_timer_tb;
  import tpw_pkg::*;
  logic                clock;
  logic                rst;
  tpw_apb_req_t        req;
  tpw_apb_rsp_t        rsp;
  tpw_pins_t           pins;
  tpw_cpu_t            cpu;
  logic                wpin;
  logic                oe_n;
  logic                irq;
  logic                wake;
  logic [15:0]         high_len;
  logic [15:0]         period_len;
  logic [15:0]         edges;
  logic [31:0]         rdat;
  logic                rerr;
  logic [7:0]          seed;
  logic [7:0]          c1;
  logic [7:0]          c2;
  logic [15:0]         e0;
  int                  num_errors;
  int                  cmp_count;
  int                  k;
  // clock codes and their cycles per tick; external pin toggles every 3
  localparam logic [1:0] CODES [4] = '{2'h1, 2'h0, 2'h3, 2'h2};
  localparam int         DIVS [4]  = '{2, 4, 6, 8};

  tpw_timer u_tpw_timer (
    .clock            (clock),
    .rst              (rst),
    .apb_req          (req),
    .apb_rsp          (rsp),
    .pins             (pins),
    .cpu              (cpu),
    .waveform_out_pin (wpin),
    .waveform_oe_n    (oe_n),
    .timer_irq        (irq),
    .wait_wake        (wake)
  );

  tpw_wave_load u_tpw_wave_load (
    .clock      (clock),
    .rst        (rst),
    .pin        (wpin),
    .oe_n       (oe_n),
    .high_len   (high_len),
    .period_len (period_len),
    .edges      (edges)
  );

  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  // free-running external timer clock, six cycles per period
  always begin
    repeat (3) @(posedge clock);
    pins.ext_clk <= ~pins.ext_clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; answer taken at the edge where pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clock);
    req.psel    <= 1'h1;
    req.penable <= 1'h0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= {24'h00_0000, d};
    @(posedge clock);
    req.penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (rsp.pready === 1'h1)
        break;
    end
    if (i == 20) begin
      num_errors++;
      tally_and_finish();
    end
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel    <= 1'h0;
    req.penable <= 1'h0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'h0, a, 8'h00);
    chk(rdat, {24'h00_0000, exp});
  endtask

  // bounded wait for a pin level, sampled at rising edges
  task wait_pin(input logic v);
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge clock);
      if (wpin === v)
        break;
    end
    if (i == 2000) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  initial begin
    rst = 1'h1;
    req = '0;
    pins = '0;
    cpu = '0;
    cpu.global_mask = 1'h1;
    cpu.halt_mode = 1'h1;
    num_errors = 0;
    cmp_count = 0;
    seed = 8'h3C;
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    // reset values; halt keeps the counter at its reset value
    rd_chk(OFS_CTRL1, 8'h00);
    rd_chk(OFS_CMP1_HI, 8'h80);
    rd_chk(OFS_CMP2_LO, 8'h00);
    rd_chk(OFS_CNT_HI, 8'hFF);
    rd_chk(OFS_STATUS, 8'h00);
    chk(wpin, 1'h0);
    chk(oe_n, 1'h1);
    apb(1'h1, 8'h34, 8'h5A);
    chk(rerr, 1'h1);
    repeat (40) @(posedge clock);
    rd_chk(OFS_CNT_LO, 8'hFC);
    // leave halt; four /4 ticks roll the counter over
    @(posedge clock);
    cpu.halt_mode <= 1'h0;
    cpu.global_mask <= 1'h0;
    repeat (40) @(posedge clock);
    rd_chk(OFS_STATUS, 8'h20);
    chk(irq, 1'h0);
    apb(1'h1, OFS_CTRL1, 8'h80);
    @(negedge clock);
    chk(irq, 1'h0);
    apb(1'h1, OFS_CTRL1, 8'h20);
    @(negedge clock);
    chk(irq, 1'h1);
    @(posedge clock);
    cpu.global_mask <= 1'h1;
    @(negedge clock);
    chk(irq, 1'h0);
    apb(1'h0, OFS_CNT_LO, 8'h00);
    rd_chk(OFS_STATUS, 8'h00);
    // second reset in mid-run, under halt, parks the counter at its FFFC reset value
    @(posedge clock);
    cpu.halt_mode <= 1'h1;
    rst <= 1'h1;
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    rd_chk(OFS_CTRL1, 8'h00);
    rd_chk(OFS_CNT_LO, 8'hFC);
    // pwm sweep over every clock code, compares rewritten under halt
    apb(1'h1, OFS_CTRL1, 8'h81);
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      c1 = 8'h08 + {4'h0, seed[3:0]};
      seed = lfsr(seed);
      c2 = c1 + 8'h04 + {4'h0, seed[3:0]};
      // halt while rewriting so no period end falls in an inhibit gap
      @(posedge clock);
      cpu.halt_mode <= 1'h1;
      apb(1'h1, OFS_CMP1_HI, 8'h00);
      apb(1'h1, OFS_CMP1_LO, c1);
      apb(1'h1, OFS_CMP2_HI, 8'h00);
      apb(1'h1, OFS_CMP2_LO, c2);
      apb(1'h1, OFS_CTRL2, {4'hB, CODES[k], 2'h1});
      // drop the period flag so the later read shows a fresh one
      apb(1'h0, OFS_STATUS, 8'h00);
      apb(1'h0, OFS_CAP1_LO, 8'h00);
      @(posedge clock);
      cpu.halt_mode <= 1'h0;
      repeat (1200 + 3 * (c2 + 5) * DIVS[k]) @(posedge clock);
      chk(period_len, (c2 + 5) * DIVS[k]);
      chk(high_len, (c2 - c1) * DIVS[k]);
      chk(oe_n, 1'h0);
      apb(1'h0, OFS_STATUS, 8'h00);
      chk(rdat & 32'h0000_00C8, 32'h0000_0080);
    end
    // wake from wait on an enabled event, never from halt
    @(posedge clock);
    cpu.global_mask <= 1'h0;
    cpu.wait_mode <= 1'h1;
    @(negedge clock);
    chk(irq, 1'h1);
    chk(wake, 1'h1);
    @(posedge clock);
    cpu.halt_mode <= 1'h1;
    @(negedge clock);
    chk(wake, 1'h0);
    e0 = edges;
    // capture edges in halt only arm; pin 1 stays cut off in pwm
    @(posedge clock);
    pins.cap1 <= 1'h1;
    pins.cap2 <= 1'h1;
    repeat (5) @(posedge clock);
    pins.cap1 <= 1'h0;
    pins.cap2 <= 1'h0;
    apb(1'h0, OFS_CNT_LO, 8'h00);
    c1 = rdat[7:0];
    apb(1'h0, OFS_CNT_HI, 8'h00);
    c2 = rdat[7:0];
    apb(1'h0, OFS_STATUS, 8'h00);
    chk(rdat & 32'h0000_0010, 32'h0000_0000);
    repeat (800) @(posedge clock);
    chk(edges, e0);
    cpu.halt_irq_exit <= 1'h1;
    cpu.halt_mode <= 1'h0;
    @(posedge clock);
    cpu.halt_irq_exit <= 1'h0;
    cpu.wait_mode <= 1'h0;
    // count held in halt is what the armed capture takes at exit
    rd_chk(OFS_CAP2_HI, c2);
    rd_chk(OFS_CAP2_LO, c1);
    // clear the period flag just after a period end, well before the next
    wait_pin(1'h1);
    wait_pin(1'h0);
    apb(1'h0, OFS_STATUS, 8'h00);
    chk(rdat & 32'h0000_0098, 32'h0000_0090);
    apb(1'h0, OFS_CAP1_LO, 8'h00);
    chk(rdat, 32'h0000_0000);
    apb(1'h0, OFS_STATUS, 8'h00);
    chk(rdat & 32'h0000_0080, 32'h0000_0000);
    // equal levels give a steady pin
    apb(1'h1, OFS_CTRL1, 8'h05);
    repeat (1000) @(posedge clock);
    e0 = edges;
    repeat (1000) @(posedge clock);
    chk(edges, e0);
    chk(wpin, 1'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* tpw_wave_load.sv */
/*
  tpw_wave_load: load circuit hanging on the timer waveform pin.
  Measures pulse high time, period and rising edge count in clock cycles.
  Assumes the pin has a pull-up when the timer does not drive it.
*/
`timescale 1ns/100ps
`default_nettype none
module tpw_wave_load (
  input  wire logic  clock,
  input  wire logic  rst,
  input  wire logic  pin,
  input  wire logic  oe_n,
  output logic [15:0] high_len,
  output logic [15:0] period_len,
  output logic [15:0] edges
);
  logic        line;
  logic        line_q;
  logic [15:0] since_rise;

  // pull-up wins whenever the timer releases the pin
  assign line = oe_n ? 1'h1 : pin;

  // cycle counts are latched on each edge so a stalled pin keeps old figures
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      line_q     <= 1'h1;
      since_rise <= 16'h0000;
      high_len   <= 16'h0000;
      period_len <= 16'h0000;
      edges      <= 16'h0000;
    end else begin
      line_q     <= line;
      since_rise <= since_rise + 16'h0001;
      if (line && !line_q) begin
        period_len <= since_rise;
        since_rise <= 16'h0001;
        edges      <= edges + 16'h0001;
      end
      if (!line && line_q) begin
        high_len <= since_rise;
      end
    end
  end
endmodule
`default_nettype wire
